// ===== src/sfl_pkg.sv
// Behaviour
// - at power-up every block and sector lock bit is set to one
// - single lock command 36h sets the addressed region's lock bit
// - single unlock command 39h clears the addressed region's lock bit
// - one lock bit per 4KB sector in top and bottom sixteen, else per 64KB
// - gang lock command 7Eh sets every lock bit at once
// - gang unlock command 98h clears every lock bit at once
// - lock commands and lock-status read act only in individual protection mode
// - single lock/unlock is opcode then three or four address bytes
// - address bytes follow address mode, three by default, four in wide mode
// - gang lock/unlock is the opcode byte alone
// - these commands are rejected unless chip select rises on a byte boundary
// - lock-status read 3Ch returns the region's status in the first output byte
// - status reads one when the region is protected, zero when open
// - fail-flag clear resets both program and erase fail flags
// - after busy output enable, serial output shows ready/busy in continuous program
// - after busy output disable, serial output stops showing ready/busy
// - parameter read is 5Ah, three address bytes, one dummy, then data out
// - raising chip select at any point ends the parameter read
// - write protect pin low protects everything in individual protection mode
// - fail-flag clear uses opcode 30h
// - program fail flag sets when programming a protected region
package sfl_pkg;
  localparam logic [7:0] OP_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7e;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] OP_LOCK_STATUS = 8'h3c;
  localparam logic [7:0] OP_FAIL_CLEAR = 8'h30;
  localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
  localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;
  localparam logic [7:0] OP_PARAM_READ = 8'h5a;
  localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
  localparam logic [2:0] PARAM_ADDR_BYTES = 3'h3;
  localparam logic [3:0] OPCODE_ONLY_LEN = 4'h1;
  localparam int NUM_LOCK = 542;
  localparam int BLK_MSB = 24;
  localparam int BLK_LSB = 16;
  localparam int SECT_MSB = 15;
  localparam int SECT_LSB = 12;
  localparam logic [8:0] BLK_BOTTOM = 9'h000;
  localparam logic [8:0] BLK_TOP = 9'h1ff;
  localparam logic [9:0] LOCK_TOP_BASE = 10'h010;
  // uniform block n sits at n + 31: skips the 32 sector bits, block 0 has none
  localparam logic [9:0] LOCK_BLK_BASE = 10'h01f;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic [7:0] STATUS_LOCKED = 8'h01;
  localparam logic [7:0] STATUS_OPEN = 8'h00;
  localparam logic [3:0] PIN_IDLE = 4'h9;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic wp_n;
  } sfl_pins_type;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_OUT, PH_TAIL} sfl_phase_type;
endpackage

// ===== src/sfl_block_lock.sv
`timescale 1ns/1ns
module sfl_block_lock (
  input wire logic core_clk, // 25 MHz core clock
  input wire logic srst, // synchronous reset, active high
  input sfl_pkg::sfl_pins_type pins, // chip select, serial clock, serial in, write protect
  input wire logic individual_protect_select, // individual protection mode bit
  input wire logic wide_address_mode, // four address bytes when high
  input wire logic write_enable_latch, // write enable latch state
  input wire logic continuous_program_mode, // device is in continuous program mode
  input wire logic array_busy, // program or erase in progress
  input wire logic [31:0] chk_addr, // array engine target address
  input wire logic program_attempt, // pulse: program starts at chk_addr
  input wire logic erase_attempt, // pulse: erase starts at chk_addr
  input wire logic program_fail_evt, // pulse: program failed
  input wire logic erase_fail_evt, // pulse: erase failed
  input wire logic [7:0] param_data, // parameter table byte at param_addr_r
  output logic so_r, // serial output data
  output logic so_oe_n_r, // serial output enable, low drives
  output logic chk_locked_r, // chk_addr region refuses program and erase
  output logic program_fail_r, // program fail flag
  output logic erase_fail_r, // erase fail flag
  output logic busy_output_en_r, // ready/busy on serial output enabled
  output logic lock_cmd_done_r, // pulse: lock bits changed
  output logic [23:0] param_addr_r // parameter table byte address
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] filt_nxt;
  sfl_pkg::sfl_pins_type filt_r;
  sfl_pkg::sfl_pins_type filt_d_r;
  sfl_pkg::sfl_phase_type phase_r;
  sfl_pkg::sfl_phase_type phase_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [3:0] byte_cnt_r;
  logic [3:0] byte_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] opcode_r;
  logic [7:0] opcode_nxt;
  logic [2:0] addr_bytes_r;
  logic [2:0] addr_bytes_nxt;
  logic [2:0] addr_left_r;
  logic [2:0] addr_left_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic [7:0] out_sh_r;
  logic [7:0] out_sh_nxt;
  logic [23:0] param_addr_nxt;
  logic so_nxt;
  logic so_oe_n_nxt;
  logic [sfl_pkg::NUM_LOCK-1:0] lock_r;

  // pins: three stages, a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (srst) begin
          s1_r[gi] <= sfl_pkg::PIN_IDLE[gi];
          s2_r[gi] <= sfl_pkg::PIN_IDLE[gi];
          s3_r[gi] <= sfl_pkg::PIN_IDLE[gi];
        end else begin
          s1_r[gi] <= pins[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
        end
      end
      assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      filt_r <= sfl_pkg::PIN_IDLE;
      filt_d_r <= sfl_pkg::PIN_IDLE;
    end else begin
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  function automatic logic [9:0] lock_idx(input logic [31:0] a);
    logic [8:0] blk;
    blk = a[sfl_pkg::BLK_MSB:sfl_pkg::BLK_LSB];
    if (blk == sfl_pkg::BLK_BOTTOM) begin
      lock_idx = {6'h00, a[sfl_pkg::SECT_MSB:sfl_pkg::SECT_LSB]};
    end else if (blk == sfl_pkg::BLK_TOP) begin
      lock_idx = sfl_pkg::LOCK_TOP_BASE + {6'h00, a[sfl_pkg::SECT_MSB:sfl_pkg::SECT_LSB]};
    end else begin
      lock_idx = sfl_pkg::LOCK_BLK_BASE + {1'b0, blk};
    end
  endfunction

  // bp mode protection lives elsewhere, so outside individual mode this reports open
  function automatic logic region_locked(input logic [31:0] a);
    region_locked = individual_protect_select & (lock_r[lock_idx(a)] | ~filt_r.wp_n);
  endfunction

  wire cs_low = ~filt_r.cs_n;
  wire cs_fall = filt_d_r.cs_n & ~filt_r.cs_n;
  wire cs_rise = ~filt_d_r.cs_n & filt_r.cs_n;
  wire sclk_rise = cs_low & ~filt_d_r.sclk & filt_r.sclk;
  wire sclk_fall = cs_low & filt_d_r.sclk & ~filt_r.sclk;
  wire byte_done = sclk_rise & (bit_cnt_r == 3'h7);
  wire [7:0] rx_byte = {shift_r[6:0], filt_r.si};
  wire [31:0] addr_full = {addr_r[23:0], rx_byte};
  wire last_addr = (phase_r == sfl_pkg::PH_ADDR) & (addr_left_r == 3'h1);
  wire rx_lock_cmd = (rx_byte == sfl_pkg::OP_SINGLE_LOCK) | (rx_byte == sfl_pkg::OP_SINGLE_UNLOCK) |
                     (rx_byte == sfl_pkg::OP_LOCK_STATUS);
  wire is_param = opcode_r == sfl_pkg::OP_PARAM_READ;
  wire is_status = opcode_r == sfl_pkg::OP_LOCK_STATUS;
  wire [7:0] status_byte = region_locked(last_addr ? addr_full : addr_r) ?
                           sfl_pkg::STATUS_LOCKED : sfl_pkg::STATUS_OPEN;

  // commands only count when chip select rises on a byte boundary
  wire on_boundary = cs_rise & (bit_cnt_r == 3'h0);
  wire single_len = byte_cnt_r == (sfl_pkg::OPCODE_ONLY_LEN + {1'b0, addr_bytes_r});
  wire opcode_len = byte_cnt_r == sfl_pkg::OPCODE_ONLY_LEN;
  wire lock_allowed = individual_protect_select & write_enable_latch;
  wire exec_single = on_boundary & lock_allowed & single_len &
                     ((opcode_r == sfl_pkg::OP_SINGLE_LOCK) | (opcode_r == sfl_pkg::OP_SINGLE_UNLOCK));
  wire exec_gang = on_boundary & lock_allowed & opcode_len &
                   ((opcode_r == sfl_pkg::OP_GANG_LOCK) | (opcode_r == sfl_pkg::OP_GANG_UNLOCK));
  wire exec_clear = on_boundary & opcode_len & (opcode_r == sfl_pkg::OP_FAIL_CLEAR);
  wire exec_busy_en = on_boundary & opcode_len & (opcode_r == sfl_pkg::OP_BUSY_OUT_EN);
  wire exec_busy_dis = on_boundary & opcode_len & (opcode_r == sfl_pkg::OP_BUSY_OUT_DIS);

  wire chk_locked_c = region_locked(chk_addr);
  wire busy_on_so = busy_output_en_r & continuous_program_mode & cs_low;

  always_comb begin
    phase_nxt = phase_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    shift_nxt = shift_r;
    opcode_nxt = opcode_r;
    addr_bytes_nxt = addr_bytes_r;
    addr_left_nxt = addr_left_r;
    addr_nxt = addr_r;
    out_sh_nxt = out_sh_r;
    param_addr_nxt = param_addr_r;
    if (cs_fall) begin
      phase_nxt = sfl_pkg::PH_OPCODE;
      bit_cnt_nxt = 3'h0;
      byte_cnt_nxt = 4'h0;
      addr_nxt = 32'h0000_0000;
    end else if (sclk_rise) begin
      shift_nxt = rx_byte;
      bit_cnt_nxt = bit_cnt_r + 3'h1;
    end
    if (byte_done) begin
      if (byte_cnt_r != 4'hf) begin
        byte_cnt_nxt = byte_cnt_r + 4'h1;
      end
      case (phase_r)
        sfl_pkg::PH_OPCODE: begin
          opcode_nxt = rx_byte;
          addr_bytes_nxt = wide_address_mode ? sfl_pkg::ADDR_BYTES_WIDE : sfl_pkg::ADDR_BYTES_NARROW;
          addr_left_nxt = addr_bytes_nxt;
          if (rx_lock_cmd & individual_protect_select) begin
            phase_nxt = sfl_pkg::PH_ADDR;
          end else if (rx_byte == sfl_pkg::OP_PARAM_READ) begin
            phase_nxt = sfl_pkg::PH_ADDR;
            addr_left_nxt = sfl_pkg::PARAM_ADDR_BYTES;
          end else begin
            phase_nxt = sfl_pkg::PH_TAIL;
          end
        end
        sfl_pkg::PH_ADDR: begin
          addr_nxt = addr_full;
          addr_left_nxt = addr_left_r - 3'h1;
          if (last_addr) begin
            if (is_param) begin
              phase_nxt = sfl_pkg::PH_DUMMY;
              param_addr_nxt = addr_full[23:0];
            end else if (is_status) begin
              phase_nxt = sfl_pkg::PH_OUT;
              out_sh_nxt = status_byte;
            end else begin
              phase_nxt = sfl_pkg::PH_TAIL;
            end
          end
        end
        sfl_pkg::PH_DUMMY: begin
          phase_nxt = sfl_pkg::PH_OUT;
          out_sh_nxt = param_data;
          param_addr_nxt = param_addr_r + 24'h000001;
        end
        sfl_pkg::PH_OUT: begin
          // status read repeats its byte; parameter read streams until chip select rises
          if (is_param) begin
            out_sh_nxt = param_data;
            param_addr_nxt = param_addr_r + 24'h000001;
          end else begin
            out_sh_nxt = status_byte;
          end
        end
        default: begin
          phase_nxt = sfl_pkg::PH_TAIL;
        end
      endcase
    end else if (sclk_fall & (phase_r == sfl_pkg::PH_OUT)) begin
      out_sh_nxt = {out_sh_r[6:0], 1'b0};
    end
  end

  // data changes on the falling edge so it is stable when the host samples it at the end of the high phase
  always_comb begin
    so_nxt = so_r;
    so_oe_n_nxt = 1'b1;
    if (cs_low & (phase_r == sfl_pkg::PH_OUT)) begin
      so_oe_n_nxt = 1'b0;
      if (sclk_fall) begin
        so_nxt = out_sh_r[7];
      end
    end else if (busy_on_so) begin
      so_oe_n_nxt = 1'b0;
      so_nxt = ~array_busy;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_r <= sfl_pkg::PH_TAIL;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      opcode_r <= 8'h00;
      addr_bytes_r <= sfl_pkg::ADDR_BYTES_NARROW;
      addr_left_r <= 3'h0;
      addr_r <= 32'h0000_0000;
      out_sh_r <= 8'h00;
      param_addr_r <= 24'h000000;
    end else begin
      phase_r <= phase_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r <= shift_nxt;
      opcode_r <= opcode_nxt;
      addr_bytes_r <= addr_bytes_nxt;
      addr_left_r <= addr_left_nxt;
      addr_r <= addr_nxt;
      out_sh_r <= out_sh_nxt;
      param_addr_r <= param_addr_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_r <= {sfl_pkg::NUM_LOCK{sfl_pkg::LOCK_RESET}};
    end else if (exec_gang) begin
      lock_r <= {sfl_pkg::NUM_LOCK{opcode_r == sfl_pkg::OP_GANG_LOCK}};
    end else if (exec_single) begin
      lock_r[lock_idx(addr_r)] <= opcode_r == sfl_pkg::OP_SINGLE_LOCK;
    end
  end

  // a failure landing with the clear still sets the flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      program_fail_r <= 1'b0;
      erase_fail_r <= 1'b0;
      busy_output_en_r <= 1'b0;
      chk_locked_r <= 1'b1;
      lock_cmd_done_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else begin
      program_fail_r <= (program_fail_r & ~exec_clear) | program_fail_evt | (program_attempt & chk_locked_c);
      erase_fail_r <= (erase_fail_r & ~exec_clear) | erase_fail_evt | (erase_attempt & chk_locked_c);
      busy_output_en_r <= exec_busy_en | (busy_output_en_r & ~exec_busy_dis);
      chk_locked_r <= chk_locked_c;
      lock_cmd_done_r <= exec_single | exec_gang;
      so_r <= so_nxt;
      so_oe_n_r <= so_oe_n_nxt;
    end
  end
endmodule

// ===== verif/sfl_block_lock_assertions.sv
`timescale 1ns/1ns
module sfl_block_lock_assertions (
  input wire logic core_clk, // clock
  input wire logic srst, // reset
  input sfl_pkg::sfl_pins_type pins, // pins
  input wire logic individual_protect_select, // mode
  input wire logic write_enable_latch, // latch
  input wire logic continuous_program_mode, // cp
  input wire logic array_busy, // busy
  input wire logic [31:0] chk_addr, // addr
  input wire logic program_attempt, // pulse
  input wire logic erase_attempt, // pulse
  input wire logic so_r, // so
  input wire logic so_oe_n_r, // oe
  input wire logic chk_locked_r, // lock
  input wire logic program_fail_r, // flag
  input wire logic erase_fail_r, // flag
  input wire logic busy_output_en_r, // rb
  input wire logic lock_cmd_done_r // done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_pfail; program_attempt && chk_locked_r && $stable(chk_addr) |=> program_fail_r; endproperty
  a_pfail: assert property (p_pfail) else $error("program fail missed");
  property p_efail; erase_attempt && chk_locked_r && $stable(chk_addr) |=> erase_fail_r; endproperty
  a_efail: assert property (p_efail) else $error("erase fail missed");
  property p_clr; $fell(program_fail_r) || $fell(erase_fail_r) |-> pins.cs_n && $past(pins.cs_n, 3); endproperty
  a_clr: assert property (p_clr) else $error("flag cleared mid frame");
  property p_oe; pins.cs_n [*8] |-> so_oe_n_r; endproperty
  a_oe: assert property (p_oe) else $error("so driven while deselected");
  property p_dcs; lock_cmd_done_r |-> pins.cs_n && $past(pins.cs_n, 2); endproperty
  a_dcs: assert property (p_dcs) else $error("lock change before deselect");
  property p_dmode; lock_cmd_done_r |-> individual_protect_select && write_enable_latch; endproperty
  a_dmode: assert property (p_dmode) else $error("lock change not allowed");
  property p_wp; (individual_protect_select && !pins.wp_n) [*8] |-> chk_locked_r; endproperty
  a_wp: assert property (p_wp) else $error("open region under wp");
  property p_rb; (busy_output_en_r && continuous_program_mode && !pins.cs_n && !array_busy) [*8] |-> so_r; endproperty
  a_rb: assert property (p_rb) else $error("ready not on so");
endmodule

// ===== verif/sfl_host_model.sv
`timescale 1ns/1ns
module sfl_host_model (
  input wire logic core_clk, // clock
  input wire logic so, // device serial out
  input wire logic wp_n, // write protect level
  output sfl_pkg::sfl_pins_type pins // pin bundle
);
  initial pins = sfl_pkg::PIN_IDLE;
  always @(posedge core_clk) pins.wp_n <= wp_n;
  // mode 0, 8 core cycles a bit; sclk stands low outside frames
  task automatic frame(input logic [63:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge core_clk) pins.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      pins.si <= d[63 - i];
      repeat (4) @(posedge core_clk);
      pins.sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      rx = {rx[6:0], so};
      pins.sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    pins.cs_n <= 1'b1;
    // no pull on si: flip it so a stale level never passes for data
    pins.si <= ~pins.si;
    repeat (12) @(posedge core_clk);
  endtask
endmodule

// ===== verif/sfl_block_lock_tb_top.sv
`timescale 1ns/1ns
module sfl_block_lock_tb_top;
  typedef struct packed {logic [7:0] op; logic [23:0] a; logic [2:0] na; logic ips; logic wel; logic dn; logic [7:0] st;} sfl_row_type;
  logic core_clk = 1'b0, srst = 1'b1, individual_protect_select = 1'b1, write_enable_latch = 1'b1;
  logic wide_address_mode = 1'b0, continuous_program_mode = 1'b0, array_busy = 1'b0, wp_n = 1'b1;
  logic program_attempt = 1'b0, erase_attempt = 1'b0, program_fail_evt = 1'b0, erase_fail_evt = 1'b0;
  logic [31:0] chk_addr = 32'h00050000;
  logic so_r, so_oe_n_r, chk_locked_r, program_fail_r, erase_fail_r, busy_output_en_r, lock_cmd_done_r;
  logic [23:0] param_addr_r;
  logic seen_done = 1'b0;
  logic [7:0] rx;
  int mismatches = 0;
  int check_count = 0;
  sfl_pkg::sfl_pins_type pins;
  // table stand-in: byte value follows its address
  wire logic [7:0] param_data = param_addr_r[7:0] + 8'h40;
  sfl_row_type rows [9] = '{
    '{8'h39, 24'h050000, 3'h3, 1'b1, 1'b1, 1'b1, 8'h00}, '{8'h36, 24'h050000, 3'h3, 1'b1, 1'b1, 1'b1, 8'h01},
    '{8'h39, 24'h001000, 3'h3, 1'b1, 1'b1, 1'b1, 8'h00}, '{8'h39, 24'h050000, 3'h3, 1'b1, 1'b0, 1'b0, 8'h01},
    '{8'h39, 24'h050000, 3'h3, 1'b0, 1'b1, 1'b0, 8'h01}, '{8'h98, 24'h000000, 3'h0, 1'b1, 1'b1, 1'b1, 8'h00},
    '{8'h36, 24'h001000, 3'h3, 1'b1, 1'b1, 1'b1, 8'h01}, '{8'h30, 24'h002000, 3'h0, 1'b1, 1'b1, 1'b0, 8'h00},
    '{8'h7e, 24'h050000, 3'h0, 1'b1, 1'b1, 1'b1, 8'h01}};
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (lock_cmd_done_r === 1'b1) seen_done <= 1'b1;
  sfl_block_lock i_dut (.*);
  sfl_host_model i_host (.core_clk(core_clk), .so(so_r), .wp_n(wp_n), .pins(pins));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int n);
    seen_done = 1'b0;
    i_host.frame({op, a << (8 * (4 - na)), 24'h0}, n, rx);
  endtask
  task automatic stat(input logic [31:0] a, input int na, input logic [7:0] exp);
    cmd(8'h3c, a, na, 16 + 8 * na);
    check(rx, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (8) @(posedge core_clk);
    stat(32'h000a0000, 3, 8'h01);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      individual_protect_select <= rows[i].ips;
      write_enable_latch <= rows[i].wel;
      @(posedge core_clk);
      cmd(rows[i].op, {8'h0, rows[i].a}, rows[i].na, 8 + 8 * rows[i].na);
      check({7'h0, seen_done}, {7'h0, rows[i].dn});
      individual_protect_select <= 1'b1;
      stat({8'h0, rows[i].a}, 3, rows[i].st);
    end
    $display("test table done");
    cmd(8'h39, 32'h00050000, 3, 31);
    check({7'h0, seen_done}, 8'h00);
    wide_address_mode <= 1'b1;
    cmd(8'h39, 32'h01200000, 4, 40);
    check({7'h0, seen_done}, 8'h01);
    cmd(8'h39, 32'h00050000, 3, 32);
    check({7'h0, seen_done}, 8'h00);
    stat(32'h01200000, 4, 8'h00);
    wide_address_mode <= 1'b0;
    $display("test framing done");
    cmd(8'h98, 32'h0, 0, 8);
    wp_n <= 1'b0;
    stat(32'h00050000, 3, 8'h01);
    wp_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({7'h0, chk_locked_r}, 8'h00);
    cmd(8'h7e, 32'h0, 0, 8);
    program_attempt <= 1'b1;
    erase_attempt <= 1'b1;
    @(posedge core_clk);
    program_attempt <= 1'b0;
    erase_attempt <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({6'h0, program_fail_r, erase_fail_r}, 8'h03);
    cmd(8'h30, 32'h0, 0, 9);
    check({6'h0, program_fail_r, erase_fail_r}, 8'h03);
    cmd(8'h30, 32'h0, 0, 8);
    check({6'h0, program_fail_r, erase_fail_r}, 8'h00);
    $display("test flags done");
    cmd(sfl_pkg::OP_BUSY_OUT_EN, 32'h0, 0, 8);
    check({7'h0, busy_output_en_r}, 8'h01);
    continuous_program_mode <= 1'b1;
    cmd(8'h00, 32'h0, 0, 8);
    check(rx, 8'hff);
    array_busy <= 1'b1;
    cmd(8'h00, 32'h0, 0, 8);
    check(rx, 8'h00);
    array_busy <= 1'b0;
    continuous_program_mode <= 1'b0;
    cmd(sfl_pkg::OP_BUSY_OUT_DIS, 32'h0, 0, 8);
    check({7'h0, busy_output_en_r}, 8'h00);
    // ready would show as ones if the disable did not stick
    continuous_program_mode <= 1'b1;
    cmd(8'h00, 32'h0, 0, 8);
    check(rx, 8'h00);
    continuous_program_mode <= 1'b0;
    i_host.frame({sfl_pkg::OP_PARAM_READ, 24'h000010, 32'h0}, 48, rx);
    check(rx, 8'h50);
    check(param_addr_r[7:0], 8'h12);
    check({7'h0, so_oe_n_r}, 8'h01);
    $display("test busy and param done");
    give_verdict;
  end
endmodule
bind sfl_block_lock sfl_block_lock_assertions i_chk (.*);
